// ==== src/fsd_pkg.sv ====
package fsd_pkg;
  // Instruction field positions, numbered from the LSB end (bit 0 of the
  // big-endian instruction word is bit 31 here)
  localparam int OPC_HI = 31;
  localparam int OPC_LO = 26;
  localparam int SRC_HI = 25;
  localparam int SRC_LO = 21;
  localparam int BASE_HI = 20;
  localparam int BASE_LO = 16;
  localparam int IDX_HI = 15;
  localparam int IDX_LO = 11;
  localparam int XO_HI = 10;
  localparam int XO_LO = 1;
  localparam int QD_HI = 15;
  localparam int QD_LO = 2;
  localparam int QSUB_HI = 1;
  localparam int QSUB_LO = 0;
  localparam int D_HI = 15;
  localparam int D_LO = 0;
  localparam int RECORD_POS = 0;

  // Opcode values
  localparam logic [5:0] OPC_QUAD = 6'h3c;
  localparam logic [5:0] OPC_QUAD_UPD = 6'h3d;
  localparam logic [5:0] OPC_EXT = 6'h1f;
  localparam logic [5:0] OPC_SGL = 6'h34;
  localparam logic [5:0] OPC_SGL_UPD = 6'h35;
  localparam logic [9:0] XO_QUAD_IDX_UPD = 10'h3b7;
  localparam logic [9:0] XO_QUAD_IDX = 10'h397;
  localparam logic [1:0] QSUB_PLAIN = 2'h0;
  localparam logic [1:0] QSUB_UPD = 2'h1;

  // Address and size constants
  localparam logic [31:0] DWORD_STEP = 32'h0000_0008;
  localparam logic [1:0] WORD_ALIGN_PAD = 2'h0;
  localparam logic [4:0] REG_ZERO = 5'h00;
  localparam logic [4:0] REG_LAST = 5'h1f;
  localparam logic [3:0] SIZE_DWORD = 4'h8;
  localparam logic [3:0] SIZE_WORD = 4'h4;

  // Controller states
  typedef enum logic [1:0] {
    FSD_IDLE,
    FSD_FIRST,
    FSD_SECOND,
    FSD_FINISH
  } fsd_state_type;
endpackage

// ==== src/fsd_store_decode.sv ====
`timescale 1ns/1ps
// Operation
// - Opcode 60 with low bits 00 is the paired displacement store, fields source/base/disp.
// - Opcode 61 with low bits 01 is the same paired displacement store with base update.
// - Opcode 31 extended 951 is the indexed paired store with update; bit 31 is the record bit.
// - Opcode 31 extended 919 is the indexed paired store without update.
// - Paired displacement offset is the 14-bit field sign-extended to 30 bits with 00 appended.
// - Paired displacement address is the offset alone for base field 0, else base plus offset.
// - Paired forms store the source register at the address and the next register 8 bytes up.
// - Indexed address is base plus index, or the index alone when the base field is 0.
// - Paired update forms write the address back to the base register when its field is nonzero and no access faulted.
// - None of these stores touches the float status register or condition field 0.
// - Opcode 52 is the single store with a 16-bit displacement, converting to single.
// - Single address is the sign-extended 16-bit displacement, plus base when field nonzero.
// - Opcode 53 is the single store with update, same layout and address as opcode 52.
// - Single update writes back only for nonzero base field and a fault-free access.
// - Paired encodings are accepted only when the paired extension is present.
module fsd_store_decode
  import fsd_pkg::*;
#(
  parameter bit HAS_PAIRED = 1'b1,
  parameter int AW = 32
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Instruction issue
  input wire logic issue_valid_i,
  output logic issue_ready_o,
  input wire logic [31:0] instr_i,
  // Register file read ports
  output logic [4:0] base_reg_field_o,
  output logic [4:0] index_reg_field_o,
  input wire logic [AW-1:0] base_value_i,
  input wire logic [AW-1:0] index_value_i,
  output logic [4:0] fp_rd_sel_o,
  input wire logic [63:0] fp_rd_data_i,
  input wire logic [31:0] fp_single_i,
  // Memory write request
  output logic mem_req_o,
  input wire logic mem_ack_i,
  input wire logic mem_fault_i,
  output logic [AW-1:0] mem_addr_o,
  output logic [63:0] mem_data_o,
  output logic [3:0] mem_size_o,
  // Base register write-back and status
  output logic int_wb_en_o,
  output logic [4:0] int_wb_sel_o,
  output logic [AW-1:0] int_wb_data_o,
  output logic illegal_o,
  output logic fault_o,
  output logic fpscr_we_o,
  output logic cr0_we_o,
  output logic done_o
);

  // Sign-extend a 16-bit word from its bit 15 to the address width
  function automatic logic [AW-1:0] sext16(input logic [15:0] v);
    sext16 = {{(AW-16){v[15]}}, v};
  endfunction

  // Partner register of a pair; the last register wraps to register 0
  function automatic logic [4:0] pair_next(input logic [4:0] r);
    if (r == REG_LAST) begin
      pair_next = REG_ZERO;
    end else begin
      pair_next = r + 5'h01;
    end
  endfunction

  // Match on the extended opcode under the shared primary opcode
  function automatic logic ext_match(input logic [5:0] op, input logic [9:0] ext,
      input logic [9:0] want);
    ext_match = (op == OPC_EXT) && (ext == want);
  endfunction

  // Field extraction
  wire [5:0] opc = instr_i[OPC_HI:OPC_LO];
  wire [9:0] xo = instr_i[XO_HI:XO_LO];
  wire [1:0] qsub = instr_i[QSUB_HI:QSUB_LO];
  wire [4:0] fp_source_reg = instr_i[SRC_HI:SRC_LO];
  wire [4:0] base_reg_field = instr_i[BASE_HI:BASE_LO];
  wire [4:0] index_reg_field = instr_i[IDX_HI:IDX_LO];
  wire [13:0] quad_disp_field = instr_i[QD_HI:QD_LO];
  wire [15:0] disp_field = instr_i[D_HI:D_LO];
  wire record_bit = instr_i[RECORD_POS];

  // Paired form decode, each on its full opcode pattern
  wire is_q = (opc == OPC_QUAD) && (qsub == QSUB_PLAIN);
  wire is_qu = (opc == OPC_QUAD_UPD) && (qsub == QSUB_UPD);
  wire is_qux = ext_match(opc, xo, XO_QUAD_IDX_UPD);
  wire is_qx = ext_match(opc, xo, XO_QUAD_IDX);

  // Single-precision form decode
  wire is_s = (opc == OPC_SGL);
  wire is_su = (opc == OPC_SGL_UPD);

  // Paired forms exist only when the paired extension is built in
  wire is_paired_enc = is_q | is_qu | is_qux | is_qx;
  wire paired_ok = is_paired_enc & HAS_PAIRED;
  wire single_ok = is_s | is_su;
  wire known = paired_ok | single_ok;

  // Form attributes of the offered instruction
  wire upd_form = (HAS_PAIRED & (is_qu | is_qux)) | is_su;
  wire indexed = is_qux | is_qx;
  wire base_zero = (base_reg_field == REG_ZERO);

  // Offset: index register, 16-bit displacement or scaled 14-bit displacement
  wire [AW-1:0] quad_off = sext16({quad_disp_field, WORD_ALIGN_PAD});
  wire [AW-1:0] sgl_off = sext16(disp_field);
  wire [AW-1:0] disp_off = single_ok ? sgl_off : quad_off;
  wire [AW-1:0] offset = indexed ? index_value_i : disp_off;

  // Base term drops out when the base field names register 0
  wire [AW-1:0] base_term = base_zero ? '0 : base_value_i;
  wire [AW-1:0] next_target = base_term + offset;

  // Held instruction context
  fsd_state_type state;
  logic [AW-1:0] memory_target;
  logic [4:0] src_hold;
  logic [4:0] base_hold;
  logic paired;
  logic want_wb;
  logic saw_fault;

  // Pair partner comes from the held source, never from the live word
  wire [4:0] next_src = pair_next(src_hold);

  // Sequencer qualifiers
  wire idle = (state == FSD_IDLE);
  wire in_first = (state == FSD_FIRST);
  wire in_second = (state == FSD_SECOND);
  wire in_finish = (state == FSD_FINISH);
  wire accept = idle & issue_valid_i;
  wire ack_ok = mem_req_o & mem_ack_i & ~mem_fault_i;
  wire ack_bad = mem_req_o & mem_ack_i & mem_fault_i;
  wire go_second = in_first & ack_ok & paired;

  // Register read steering: live source while idle, pair partner afterwards
  assign base_reg_field_o = base_reg_field;
  assign index_reg_field_o = index_reg_field;
  assign fp_rd_sel_o = idle ? fp_source_reg : next_src;

  // Handshake outputs
  assign issue_ready_o = idle;
  assign mem_req_o = in_first | in_second;

  // Status writes that these stores never make
  assign fpscr_we_o = 1'b0;
  assign cr0_we_o = 1'b0;

  // Sequencer
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state <= FSD_IDLE;
    end else begin
      case (state)
        FSD_IDLE: begin
          if (accept && known) state <= FSD_FIRST;
        end
        FSD_FIRST: begin
          if (ack_bad || (ack_ok && !paired)) state <= FSD_FINISH;
          else if (ack_ok) state <= FSD_SECOND;
        end
        FSD_SECOND: begin
          if (mem_ack_i) state <= FSD_FINISH;
        end
        FSD_FINISH: begin
          state <= FSD_IDLE;
        end
        default: begin
          state <= FSD_IDLE;
        end
      endcase
    end
  end

  // Effective address kept for the second half and write-back
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      memory_target <= '0;
    end else if (accept) begin
      memory_target <= next_target;
    end
  end

  // Source register kept so the pair partner ignores later words
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      src_hold <= '0;
    end else if (accept) begin
      src_hold <= fp_source_reg;
    end
  end

  // Base register kept as write-back target
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      base_hold <= '0;
    end else if (accept) begin
      base_hold <= base_reg_field;
    end
  end

  // Paired flag selects one or two halves
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      paired <= 1'b0;
    end else if (accept) begin
      paired <= paired_ok;
    end
  end

  // Write-back wanted for update forms with a nonzero base field
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      want_wb <= 1'b0;
    end else if (accept) begin
      want_wb <= upd_form & ~base_zero;
    end
  end

  // Fault tracking across both halves; issue and a faulted answer never meet
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      saw_fault <= 1'b0;
    end else if (accept) begin
      saw_fault <= 1'b0;
    end else if (ack_bad) begin
      saw_fault <= 1'b1;
    end
  end

  // Store data of the live source: paired doubleword or converted single
  logic [63:0] data_sel;
  assign data_sel = paired_ok ? fp_rd_data_i : {32'h0000_0000, fp_single_i};

  // Request address: formed at issue, one doubleword up for the second half
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mem_addr_o <= '0;
    end else if (idle) begin
      mem_addr_o <= next_target;
    end else if (go_second) begin
      mem_addr_o <= memory_target + AW'(DWORD_STEP);
    end
  end

  // Request size follows the decoded form
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mem_size_o <= '0;
    end else if (idle) begin
      mem_size_o <= paired_ok ? SIZE_DWORD : SIZE_WORD;
    end
  end

  // Request data: source at issue, pair partner once the first half is taken
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mem_data_o <= '0;
    end else if (idle) begin
      mem_data_o <= data_sel;
    end else if (go_second) begin
      mem_data_o <= fp_rd_data_i;
    end
  end

  // Completion and illegal-form pulses
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      illegal_o <= 1'b0;
      done_o <= 1'b0;
      fault_o <= 1'b0;
    end else begin
      illegal_o <= accept & ~known;
      done_o <= in_finish;
      fault_o <= in_finish & saw_fault;
    end
  end

  // Base write-back only after a store accepted without fault
  wire wb_fire = in_finish & want_wb & ~saw_fault;

  // Base write-back outputs
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      int_wb_en_o <= 1'b0;
      int_wb_sel_o <= '0;
      int_wb_data_o <= '0;
    end else begin
      int_wb_en_o <= wb_fire;
      int_wb_sel_o <= base_hold;
      int_wb_data_o <= memory_target;
    end
  end

  // Record bit is decoded but never writes condition field 0
  wire unused_record = record_bit;

endmodule

// ==== tb/fsd_store_props.sv ====
`timescale 1ns/1ps
module fsd_store_props #(parameter int AW = 32) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Memory side
  input wire logic [4:0] fp_rd_sel_o,
  input wire logic mem_req_o,
  input wire logic mem_ack_i,
  input wire logic mem_fault_i,
  input wire logic [AW-1:0] mem_addr_o,
  input wire logic [3:0] mem_size_o,
  // Results
  input wire logic int_wb_en_o,
  input wire logic [4:0] int_wb_sel_o,
  input wire logic illegal_o,
  input wire logic fault_o,
  input wire logic fpscr_we_o,
  input wire logic cr0_we_o,
  input wire logic done_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // First doubleword accepted cleanly, second half follows
  sequence half_ok;
    mem_req_o && mem_ack_i && !mem_fault_i && mem_size_o == 4'h8 ##1 mem_req_o;
  endsequence
  a_next_reg_wrap: assert property (
    $rose(mem_req_o) && mem_size_o == 4'h8 |-> fp_rd_sel_o == 5'($past(fp_rd_sel_o) + 5'h1))
    else $error("bad next register");
  a_next_addr_step: assert property (
    half_ok |-> mem_addr_o == $past(mem_addr_o) + 8) else $error("bad second address");
  a_illegal_quiet: assert property (
    illegal_o |-> !mem_req_o && !done_o) else $error("illegal with activity");
  a_status_untouched: assert property (
    !fpscr_we_o && !cr0_we_o) else $error("status write");
  a_wb_gated: assert property (
    int_wb_en_o |-> done_o && !fault_o && int_wb_sel_o != 5'h0) else $error("bad writeback");
  a_fault_stops: assert property (
    mem_req_o && mem_ack_i && mem_fault_i |=> !mem_req_o [*2]) else $error("request after fault");
  a_fault_done: assert property (
    fault_o |-> done_o) else $error("fault without done");
  a_req_holds: assert property (
    mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o)) else $error("request dropped");
  a_pair_sel_holds: assert property (
    mem_req_o && $past(mem_req_o) |-> $stable(fp_rd_sel_o)) else $error("select moved");
endmodule

bind fsd_store_decode fsd_store_props #(.AW(AW)) i_fsd_store_props (.clk_i(clk_i),
  .reset_i(reset_i), .fp_rd_sel_o(fp_rd_sel_o), .mem_req_o(mem_req_o), .mem_ack_i(mem_ack_i),
  .mem_fault_i(mem_fault_i), .mem_addr_o(mem_addr_o), .mem_size_o(mem_size_o),
  .int_wb_en_o(int_wb_en_o), .int_wb_sel_o(int_wb_sel_o), .illegal_o(illegal_o),
  .fault_o(fault_o), .fpscr_we_o(fpscr_we_o), .cr0_we_o(cr0_we_o), .done_o(done_o));

// ==== tb/fsd_mem_model.sv ====
`timescale 1ns/1ps
module fsd_mem_model (
  // Clock and request
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic fault_en_i,
  // Answer
  output logic ack_o,
  output logic fault_o
);
  int wait_cnt = 0;
  initial begin
    ack_o = 1'b0;
    fault_o = 1'b0;
  end
  // Accepts after a random stall; fault line toggles while not acking
  always @(posedge clk_i) begin
    #1;
    fault_o = ~fault_o;
    if (ack_o) begin
      ack_o = 1'b0;
    end else if (req_i && wait_cnt == 0) begin
      ack_o = 1'b1;
      fault_o = fault_en_i;
      wait_cnt = $urandom_range(2, 0);
    end else if (req_i) begin
      wait_cnt--;
    end
  end
endmodule

// ==== tb/fsd_store_decode_tb_top.sv ====
`timescale 1ns/1ps
module fsd_store_decode_tb_top;
  logic clk_i = 0, reset_i = 1, issue_valid_i = 0, fault_en = 0, exp_wb = 0, pair = 0;
  logic [31:0] instr_i = 0, base_value_i = 0, index_value_i = 0, wb_ea, int_wb_data_o, mem_addr_o;
  logic issue_ready_o, mem_req_o, mem_ack_i, mem_fault_i, int_wb_en_o, illegal_o, fault_o;
  logic fpscr_we_o, cr0_we_o, done_o;
  logic [4:0] base_reg_field_o, index_reg_field_o, fp_rd_sel_o, int_wb_sel_o, wb_sel;
  logic [63:0] mem_data_o, fp_rd_data_i;
  logic [31:0] fp_single_i;
  logic [3:0] mem_size_o;
  logic [31:0] addr_q[$];
  logic [4:0] reg_q[$];
  int error_cnt = 0, samples_checked = 0, cycles = 0;
  // Register file data tells which register was read
  assign fp_rd_data_i = {2{27'h5a5a5a5, fp_rd_sel_o}};
  assign fp_single_i = {27'h3c3c3c3, fp_rd_sel_o};
  fsd_store_decode i_fsd_store_decode (.clk_i(clk_i), .reset_i(reset_i),
    .issue_valid_i(issue_valid_i), .issue_ready_o(issue_ready_o), .instr_i(instr_i),
    .base_reg_field_o(base_reg_field_o), .index_reg_field_o(index_reg_field_o),
    .base_value_i(base_value_i), .index_value_i(index_value_i), .fp_rd_sel_o(fp_rd_sel_o),
    .fp_rd_data_i(fp_rd_data_i), .fp_single_i(fp_single_i), .mem_req_o(mem_req_o),
    .mem_ack_i(mem_ack_i), .mem_fault_i(mem_fault_i), .mem_addr_o(mem_addr_o),
    .mem_data_o(mem_data_o), .mem_size_o(mem_size_o), .int_wb_en_o(int_wb_en_o),
    .int_wb_sel_o(int_wb_sel_o), .int_wb_data_o(int_wb_data_o), .illegal_o(illegal_o),
    .fault_o(fault_o), .fpscr_we_o(fpscr_we_o), .cr0_we_o(cr0_we_o), .done_o(done_o));
  fsd_mem_model i_fsd_mem_model (.clk_i(clk_i), .req_i(mem_req_o), .fault_en_i(fault_en),
    .ack_o(mem_ack_i), .fault_o(mem_fault_i));
  initial forever #50 clk_i = ~clk_i;
  task chk(input bit ok, input string msg);
    samples_checked++;
    if (!ok) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task conclude();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Compare every accepted half and every completion with the model
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 5000) begin
      error_cnt++;
      conclude();
    end
    if (mem_req_o === 1'b1 && mem_ack_i === 1'b1) begin
      chk(addr_q.size() > 0 && mem_addr_o === addr_q[0], "address");
      chk(mem_size_o === (pair ? 4'h8 : 4'h4), "size");
      chk(!pair || mem_data_o === {2{27'h5a5a5a5, reg_q[0]}}, "data");
      chk(pair || mem_data_o === {32'h0, 27'h3c3c3c3, reg_q[0]}, "single data");
      addr_q.delete(0);
      reg_q.delete(0);
    end
    if (done_o === 1'b1) begin
      chk(int_wb_en_o === exp_wb, "writeback");
      chk(!exp_wb || {int_wb_sel_o, int_wb_data_o} === {wb_sel, wb_ea}, "wb value");
      chk(fault_o === fault_en && {fpscr_we_o, cr0_we_o} === 2'h0, "status");
    end
  end
  // One instruction of form f; k picks base zero, source 31, or fault
  task run(input int f, input int k);
    logic [4:0] s, b;
    logic [15:0] r;
    logic [31:0] ins, ea;
    int n;
    s = (k == 1) ? 5'h1f : 5'($urandom);
    b = (k == 0) ? 5'h0 : 5'($urandom_range(31, 1));
    r = 16'($urandom);
    case (f)
      0: ins = {6'h3c, s, b, r[15:2], 2'h0};
      1: ins = {6'h3d, s, b, r[15:2], 2'h1};
      2: ins = {6'h1f, s, b, r[15:11], 10'h3b7, r[0]};
      3: ins = {6'h1f, s, b, r[15:11], 10'h397, r[0]};
      4: ins = {6'h34, s, b, r};
      5: ins = {6'h35, s, b, r};
      default: ins = {6'h1f, s, b, r[15:11], 10'h2d7, r[0]};
    endcase
    @(posedge clk_i) #1;
    base_value_i = $urandom;
    index_value_i = $urandom;
    ea = (f == 2 || f == 3) ? index_value_i : {{16{r[15]}}, (f < 4) ? {r[15:2], 2'h0} : r};
    if (b != 5'h0) ea = ea + base_value_i;
    pair = f < 4;
    fault_en = k == 3;
    exp_wb = (f == 1 || f == 2 || f == 5) && b != 5'h0 && k != 3;
    wb_ea = ea;
    wb_sel = b;
    if (f < 6) addr_q.push_back(ea);
    if (f < 6) reg_q.push_back(s);
    if (f < 4 && k != 3) addr_q.push_back(ea + 32'h8);
    if (f < 4 && k != 3) reg_q.push_back(s + 5'h1);
    issue_valid_i = 1'b1;
    instr_i = ins;
    @(posedge clk_i) #1;
    issue_valid_i = 1'b0;
    n = 0;
    while (done_o !== 1'b1 && illegal_o !== 1'b1 && n < 20) begin
      @(posedge clk_i) #1;
      n++;
    end
    chk(n < 20 && illegal_o === (f == 6) && addr_q.size() == 0, "completion");
  endtask
  initial begin
    void'($urandom(32'hebc30546));
    repeat (12) @(posedge clk_i);
    #1 reset_i = 1'b0;
    for (int f = 0; f < 7; f++) begin
      for (int k = 0; k < 4; k++) run(f, k);
      $display("form %0d finished", f);
    end
    conclude();
  end
endmodule
